// File: rtl/dsp_pse_pkg.sv
// Package for the pack, select and expand datapath.
// Assumes a 32-bit instruction word and 32-bit general registers.
package dsp_pse_pkg;

    // Instruction word layout
    localparam logic [5:0] MAJOR_OPC = 6'h1F;
    localparam int OPC_LSB = 26;
    localparam int SRCA_LSB = 21;
    localparam int SRCB_LSB = 16;
    localparam int DST_LSB = 11;
    localparam int SUB_LSB = 6;
    localparam int FN_LSB = 0;
    localparam int IDX_W = 5;

    // Function field classes
    localparam logic [5:0] FN_SELECT = 6'h11;
    localparam logic [5:0] FN_EXPAND = 6'h12;

    // Sub-operation codes
    localparam logic [4:0] SUB_PACK = 5'h0E;
    localparam logic [4:0] SUB_SELECT_HALFWORD_BY_FLAGS = 5'h0B;
    localparam logic [4:0] SUB_SELECT_BYTE_BY_FLAGS = 5'h03;
    localparam logic [4:0] SUB_EXP_UQ = 5'h0C;
    localparam logic [4:0] SUB_EXP_LQ = 5'h0D;
    localparam logic [4:0] SUB_EXP_UB = 5'h04;

    // Condition code position in the control register
    localparam int CC_LSB = 24;
    localparam int CC_NUM = 4;

    // Expansion padding
    localparam logic [15:0] Q31_PAD = 16'h0000;
    localparam logic [6:0] Q15_LOW_PAD = 7'h00;
    localparam logic Q15_SIGN = 1'b0;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_PACK = 3'b001,
        OP_SELECT_HALFWORD_BY_FLAGS = 3'b011,
        OP_SELECT_BYTE_BY_FLAGS = 3'b010,
        OP_EXP_UQ = 3'b110,
        OP_EXP_LQ = 3'b111,
        OP_EXP_UB = 3'b101
    } op_e;

    typedef struct packed {
        logic valid;
        logic [31:0] instr;
        logic [31:0] src_a;
        logic [31:0] src_b;
    } issue_s;

    typedef struct packed {
        logic wr_en;
        logic [4:0] dest;
        logic [31:0] data;
        logic exc_ri;
        logic exc_dis;
    } result_s;

    localparam result_s RES_RST = '0;

endpackage

// File: rtl/dsp_pack_select_expand_unit.sv
// Execute-stage datapath for halfword pack, flag-steered selection and
// precision expansion. Registers one result per issued instruction.
// Assumes the pipeline supplies both source values and the control register
// value on the same core clock; one cycle latency, no stalls.
//
// Functional notes
// - The group uses major opcode 011111 with source a, source b, dest and sub-op fields.
// - Sub-op 01110 with function 010001 selects the low-high halfword pack.
// - The pack result is source a low half above source b high half.
// - Sub-op 01011 with function 010001 selects halfword selection.
// - Flag bits 25 and 24 pick upper and lower halves, 1 from source a, 0 from source b.
// - Sub-op 00011 with function 010001 selects byte selection.
// - Flag bits 27 down to 24 pick result bytes 3 down to 0, 1 from source a.
// - Sub-op 01100 with function 010010 and a zero source a field is the upper Q31 expansion.
// - The upper Q31 expansion gives source b high half over 16 zero bits.
// - Sub-op 01101 with function 010010 and a zero source a field is the lower Q31 expansion.
// - The lower Q31 expansion gives source b low half over 16 zero bits.
// - Sub-op 00100 with function 010010 and a zero source a field is the upper byte expansion.
// - The upper byte expansion puts source b byte 3 in the upper half and byte 2 in the lower.
// - Each expanded byte gets one zero sign bit above and seven zero bits below.
// - No exception ever depends on operand values.
// - Only reserved instruction and extension-disabled exceptions may be raised.
`timescale 1ns/10ps
`default_nettype none

module dsp_pack_select_expand_unit (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire dsp_pse_pkg::issue_s issue_i,
    input wire logic [31:0] ctrl_reg_i,
    input wire logic ext_present_i,
    input wire logic ext_enable_i,
    output dsp_pse_pkg::result_s result_o
);

    function automatic dsp_pse_pkg::op_e decode_op(input logic [31:0] instr);
        logic [5:0] opc;
        logic [4:0] sub;
        logic [5:0] fn;
        dsp_pse_pkg::op_e op;
        opc = instr[dsp_pse_pkg::OPC_LSB +: 6];
        sub = instr[dsp_pse_pkg::SUB_LSB +: 5];
        fn = instr[dsp_pse_pkg::FN_LSB +: 6];
        op = dsp_pse_pkg::OP_NONE;
        if (opc != dsp_pse_pkg::MAJOR_OPC) begin
            op = dsp_pse_pkg::OP_NONE;
        end else if (fn == dsp_pse_pkg::FN_SELECT) begin
            if (sub == dsp_pse_pkg::SUB_PACK) begin
                op = dsp_pse_pkg::OP_PACK;
            end else if (sub == dsp_pse_pkg::SUB_SELECT_HALFWORD_BY_FLAGS) begin
                op = dsp_pse_pkg::OP_SELECT_HALFWORD_BY_FLAGS;
            end else if (sub == dsp_pse_pkg::SUB_SELECT_BYTE_BY_FLAGS) begin
                op = dsp_pse_pkg::OP_SELECT_BYTE_BY_FLAGS;
            end
        end else if (fn == dsp_pse_pkg::FN_EXPAND) begin
            if (sub == dsp_pse_pkg::SUB_EXP_UQ) begin
                op = dsp_pse_pkg::OP_EXP_UQ;
            end else if (sub == dsp_pse_pkg::SUB_EXP_LQ) begin
                op = dsp_pse_pkg::OP_EXP_LQ;
            end else if (sub == dsp_pse_pkg::SUB_EXP_UB) begin
                op = dsp_pse_pkg::OP_EXP_UB;
            end
        end
        return op;
    endfunction

    function automatic logic [15:0] byte_to_q15(input logic [7:0] b);
        return {dsp_pse_pkg::Q15_SIGN, b, dsp_pse_pkg::Q15_LOW_PAD};
    endfunction

    dsp_pse_pkg::result_s res_ff;
    dsp_pse_pkg::result_s nxt_res;
    dsp_pse_pkg::op_e op;
    logic [31:0] src_a;
    logic [31:0] src_b;
    logic [31:0] select_byte_by_flags;
    logic [31:0] data;
    logic is_expand;
    logic srca_bad;

    assign src_a = issue_i.src_a;
    assign src_b = issue_i.src_b;

    genvar gi;
    generate
        for (gi = 0; gi < dsp_pse_pkg::CC_NUM; gi++) begin : g_pick
            assign select_byte_by_flags[gi*8 +: 8] = ctrl_reg_i[dsp_pse_pkg::CC_LSB + gi] ?
                src_a[gi*8 +: 8] : src_b[gi*8 +: 8];
        end
    endgenerate

    always_comb begin
        op = decode_op(issue_i.instr);
        is_expand = (op == dsp_pse_pkg::OP_EXP_UQ) || (op == dsp_pse_pkg::OP_EXP_LQ) ||
            (op == dsp_pse_pkg::OP_EXP_UB);
        srca_bad = is_expand &&
            (issue_i.instr[dsp_pse_pkg::SRCA_LSB +: dsp_pse_pkg::IDX_W] != 5'h00);
        data = 32'h0000_0000;
        case (op)
            dsp_pse_pkg::OP_PACK: begin
                data = {src_a[15:0], src_b[31:16]};
            end
            dsp_pse_pkg::OP_SELECT_HALFWORD_BY_FLAGS: begin
                data[31:16] = ctrl_reg_i[dsp_pse_pkg::CC_LSB + 1] ? src_a[31:16] : src_b[31:16];
                data[15:0] = ctrl_reg_i[dsp_pse_pkg::CC_LSB] ? src_a[15:0] : src_b[15:0];
            end
            dsp_pse_pkg::OP_SELECT_BYTE_BY_FLAGS: begin
                data = select_byte_by_flags;
            end
            dsp_pse_pkg::OP_EXP_UQ: begin
                data = {src_b[31:16], dsp_pse_pkg::Q31_PAD};
            end
            dsp_pse_pkg::OP_EXP_LQ: begin
                data = {src_b[15:0], dsp_pse_pkg::Q31_PAD};
            end
            dsp_pse_pkg::OP_EXP_UB: begin
                data = {byte_to_q15(src_b[31:24]), byte_to_q15(src_b[23:16])};
            end
            default: begin
                data = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        nxt_res = dsp_pse_pkg::RES_RST;
        if (issue_i.valid && (op != dsp_pse_pkg::OP_NONE)) begin
            if (!ext_present_i || srca_bad) begin
                nxt_res.exc_ri = 1'b1;
            end else if (!ext_enable_i) begin
                nxt_res.exc_dis = 1'b1;
            end else begin
                nxt_res.wr_en = 1'b1;
                nxt_res.dest = issue_i.instr[dsp_pse_pkg::DST_LSB +: dsp_pse_pkg::IDX_W];
                nxt_res.data = data;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            res_ff <= dsp_pse_pkg::RES_RST;
        end else begin
            res_ff <= nxt_res;
        end
    end

    assign result_o = res_ff;

    // Checks on the registered result
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Operation seen one cycle back, for the result checks
    logic past_ok_ff;
    logic nxt_past_ok;
    dsp_pse_pkg::op_e past_op_ff;
    dsp_pse_pkg::op_e nxt_past_op;
    always_comb begin
        nxt_past_ok = issue_i.valid && ext_present_i && ext_enable_i && !srca_bad;
        nxt_past_op = op;
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            past_ok_ff <= 1'b0;
            past_op_ff <= dsp_pse_pkg::OP_NONE;
        end else begin
            past_ok_ff <= nxt_past_ok;
            past_op_ff <= nxt_past_op;
        end
    end

    // Independent decode for the checks
    logic chk_sel;
    logic chk_exp;
    logic chk_claim;
    logic chk_live;
    logic chk_zero_a;
    logic [4:0] chk_sub;
    always_comb begin
        chk_sub = issue_i.instr[10:6];
        chk_sel = issue_i.valid && issue_i.instr[31:26] == 6'h1F && issue_i.instr[5:0] == 6'h11;
        chk_exp = issue_i.valid && issue_i.instr[31:26] == 6'h1F && issue_i.instr[5:0] == 6'h12;
        chk_claim = (chk_sel && (chk_sub == 5'h0E || chk_sub == 5'h0B || chk_sub == 5'h03)) ||
            (chk_exp && (chk_sub == 5'h0C || chk_sub == 5'h0D || chk_sub == 5'h04));
        chk_live = ext_present_i && ext_enable_i;
        chk_zero_a = issue_i.instr[25:21] == 5'h00;
    end

    // Result shape per operation
    pack_result_a: assert property (past_ok_ff && past_op_ff == dsp_pse_pkg::OP_PACK |->
        result_o.wr_en && result_o.data == {$past(src_a[15:0]), $past(src_b[31:16])})
        else $error("pack result wrong");
    pick_half_a: assert property (past_ok_ff && past_op_ff == dsp_pse_pkg::OP_SELECT_HALFWORD_BY_FLAGS |->
        result_o.data[31:16] == ($past(ctrl_reg_i[25]) ? $past(src_a[31:16]) :
        $past(src_b[31:16])) && result_o.data[15:0] == ($past(ctrl_reg_i[24]) ?
        $past(src_a[15:0]) : $past(src_b[15:0])))
        else $error("halfword select wrong");
    pick_byte_a: assert property (past_ok_ff && past_op_ff == dsp_pse_pkg::OP_SELECT_BYTE_BY_FLAGS |->
        result_o.data[31:24] == ($past(ctrl_reg_i[27]) ? $past(src_a[31:24]) :
        $past(src_b[31:24])) && result_o.data[23:16] == ($past(ctrl_reg_i[26]) ?
        $past(src_a[23:16]) : $past(src_b[23:16])) && result_o.data[15:8] ==
        ($past(ctrl_reg_i[25]) ? $past(src_a[15:8]) : $past(src_b[15:8])) &&
        result_o.data[7:0] == ($past(ctrl_reg_i[24]) ? $past(src_a[7:0]) : $past(src_b[7:0])))
        else $error("byte select wrong");
    exp_upper_a: assert property (past_ok_ff && past_op_ff == dsp_pse_pkg::OP_EXP_UQ |->
        result_o.data == {$past(src_b[31:16]), 16'h0000})
        else $error("upper expand wrong");
    exp_lower_a: assert property (past_ok_ff && past_op_ff == dsp_pse_pkg::OP_EXP_LQ |->
        result_o.data == {$past(src_b[15:0]), 16'h0000})
        else $error("lower expand wrong");
    exp_bytes_a: assert property (past_ok_ff && past_op_ff == dsp_pse_pkg::OP_EXP_UB |->
        result_o.data == {1'b0, $past(src_b[31:24]), 7'h00, 1'b0, $past(src_b[23:16]), 7'h00})
        else $error("byte expand wrong");
    q15_pad_a: assert property (chk_exp && chk_sub == 5'h04 && chk_zero_a &&
        chk_live |=> result_o.data[31] == 1'b0 && result_o.data[22:16] == 7'h00 &&
        result_o.data[15] == 1'b0 && result_o.data[6:0] == 7'h00)
        else $error("byte expand padding wrong");

    // Decode of each claimed operation
    pack_decode_a: assert property (chk_sel && chk_sub == 5'h0E && chk_live |=>
        result_o.wr_en && result_o.data == {$past(src_a[15:0]), $past(src_b[31:16])})
        else $error("pack not decoded");
    half_decode_a: assert property (chk_sel && chk_sub == 5'h0B && chk_live |=>
        result_o.wr_en && result_o.data[31:16] == ($past(ctrl_reg_i[25]) ?
        $past(src_a[31:16]) : $past(src_b[31:16])) && result_o.data[15:0] ==
        ($past(ctrl_reg_i[24]) ? $past(src_a[15:0]) : $past(src_b[15:0])))
        else $error("halfword select not decoded");
    byte_decode_a: assert property (chk_sel && chk_sub == 5'h03 && chk_live |=>
        result_o.wr_en && result_o.data[23:16] == ($past(ctrl_reg_i[26]) ?
        $past(src_a[23:16]) : $past(src_b[23:16])) && result_o.data[15:8] ==
        ($past(ctrl_reg_i[25]) ? $past(src_a[15:8]) : $past(src_b[15:8])))
        else $error("byte select not decoded");
    upper_decode_a: assert property (chk_exp && chk_sub == 5'h0C && chk_zero_a &&
        chk_live |=> result_o.wr_en && result_o.data == {$past(src_b[31:16]), 16'h0000})
        else $error("upper expand not decoded");
    lower_decode_a: assert property (chk_exp && chk_sub == 5'h0D && chk_zero_a &&
        chk_live |=> result_o.wr_en && result_o.data == {$past(src_b[15:0]), 16'h0000})
        else $error("lower expand not decoded");
    bytes_decode_a: assert property (chk_exp && chk_sub == 5'h04 && chk_zero_a &&
        chk_live |=> result_o.wr_en && result_o.data[30:23] == $past(src_b[31:24]) &&
        result_o.data[14:7] == $past(src_b[23:16]))
        else $error("byte expand not decoded");

    // Answers and exceptions
    foreign_op_a: assert property (issue_i.instr[31:26] != 6'h1F |=> !result_o.wr_en &&
        !result_o.exc_ri && !result_o.exc_dis)
        else $error("foreign opcode accepted");
    unclaimed_a: assert property (!chk_claim |=> result_o == dsp_pse_pkg::RES_RST)
        else $error("unclaimed instruction answered");
    one_answer_a: assert property (
        $onehot0({result_o.wr_en, result_o.exc_ri, result_o.exc_dis}))
        else $error("more than one answer");
    srca_field_a: assert property (chk_claim && chk_exp && !chk_zero_a |=>
        result_o.exc_ri && !result_o.wr_en)
        else $error("nonzero source a field accepted");
    absent_exc_a: assert property (chk_claim && !ext_present_i |=>
        result_o.exc_ri && !result_o.exc_dis && !result_o.wr_en)
        else $error("absent extension not reserved");
    disabled_exc_a: assert property (issue_i.valid && op != dsp_pse_pkg::OP_NONE &&
        ext_present_i && !srca_bad && !ext_enable_i |=> result_o.exc_dis && !result_o.wr_en)
        else $error("disable exception missing");
    disabled_only_a: assert property (chk_claim && ext_present_i && !ext_enable_i &&
        (chk_sel || chk_zero_a) |=> result_o.exc_dis && !result_o.exc_ri && !result_o.wr_en)
        else $error("disabled extension answered wrongly");
    live_write_a: assert property (chk_claim && chk_live && (chk_sel || chk_zero_a) |=>
        result_o.wr_en && !result_o.exc_ri && !result_o.exc_dis)
        else $error("operand dependent exception");
    dest_field_a: assert property (result_o.wr_en |->
        result_o.dest == $past(issue_i.instr[15:11]))
        else $error("destination index wrong");
    quiet_data_a: assert property (!result_o.wr_en |->
        result_o.data == 32'h0000_0000 && result_o.dest == 5'h00)
        else $error("data shown without write");

    // Main scenarios reached
    pack_seen_c: cover property (past_ok_ff && past_op_ff == dsp_pse_pkg::OP_PACK);
    pick_mixed_c: cover property (past_ok_ff && past_op_ff == dsp_pse_pkg::OP_SELECT_BYTE_BY_FLAGS &&
        $past(ctrl_reg_i[27:24]) == 4'hA);
    expand_seen_c: cover property (past_ok_ff && past_op_ff == dsp_pse_pkg::OP_EXP_UB);
    reserved_c: cover property (result_o.exc_ri);
    disabled_c: cover property (result_o.exc_dis);

endmodule

`default_nettype wire

// File: sim/pipe_issue_model.sv
// Pipeline model: presents one issue a cycle to the datapath.
// Assumes the caller steps it once per core clock.
`timescale 1ns/10ps
`default_nettype none

module pipe_issue_model (
    input wire logic core_clk_i,
    output dsp_pse_pkg::issue_s issue_o,
    output logic [31:0] ctrl_reg_o,
    output logic ext_present_o,
    output logic ext_enable_o
);
    initial begin
        issue_o = '0;
        ctrl_reg_o = 32'h00000000;
        ext_present_o = 1'b1;
        ext_enable_o = 1'b1;
    end

    // Drives one cycle, 1 ns after the edge
    task automatic step(input logic vld, input logic [31:0] instr, input logic [31:0] a,
                        input logic [31:0] b, input logic [3:0] cc, input logic pres,
                        input logic en);
        @(posedge core_clk_i);
        #1;
        issue_o.valid = vld;
        // Idle operands toggle, never a stale copy
        issue_o.instr = vld ? instr : ~issue_o.instr;
        issue_o.src_a = vld ? a : ~issue_o.src_a;
        issue_o.src_b = vld ? b : ~issue_o.src_b;
        // Bits outside the flags toggle to expose misuse
        ctrl_reg_o = {~ctrl_reg_o[31:28], cc, ~ctrl_reg_o[23:0]};
        ext_present_o = pres;
        ext_enable_o = en;
    endtask
endmodule

`default_nettype wire

// File: sim/dsp_pack_select_expand_unit_test.sv
// Self-checking bench for the pack, select and expand datapath.
// Assumes one-cycle latency and a result slot on every cycle.
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, s); end end

module dsp_pack_select_expand_unit_test;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    dsp_pse_pkg::issue_s issue;
    dsp_pse_pkg::result_s result;
    logic [31:0] ctrl_reg;
    logic ext_present;
    logic ext_enable;
    dsp_pse_pkg::result_s expq[$];
    int n_fail = 0;
    int samples_checked = 0;
    logic [10:0] ops[6] = '{11'h22E, 11'h22B, 11'h223, 11'h24C, 11'h24D, 11'h244};

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    pipe_issue_model pipe (.core_clk_i(core_clk), .issue_o(issue), .ctrl_reg_o(ctrl_reg),
        .ext_present_o(ext_present), .ext_enable_o(ext_enable));

    dsp_pack_select_expand_unit uut (.core_clk_i(core_clk), .rst_n_i(rst_n),
        .issue_i(issue), .ctrl_reg_i(ctrl_reg), .ext_present_i(ext_present),
        .ext_enable_i(ext_enable), .result_o(result));

    function automatic logic [31:0] enc(input logic [4:0] ra, input logic [10:0] fs);
        return {6'h1F, ra, 5'($urandom), 5'($urandom), fs[4:0], fs[10:5]};
    endfunction

    function automatic dsp_pse_pkg::result_s model(input logic v, input logic [31:0] i,
            input logic [31:0] a, input logic [31:0] b, input logic [3:0] cc,
            input logic p, input logic en);
        dsp_pse_pkg::result_s r;
        logic [31:0] d;
        r = '0;
        if (!v || i[31:26] != 6'h1F) return r;
        case ({i[5:0], i[10:6]})
            {6'h11, 5'h0E}: d = {a[15:0], b[31:16]};
            {6'h11, 5'h0B}: d = {cc[1] ? a[31:16] : b[31:16], cc[0] ? a[15:0] : b[15:0]};
            {6'h11, 5'h03}: d = {cc[3] ? a[31:24] : b[31:24], cc[2] ? a[23:16] : b[23:16],
                                 cc[1] ? a[15:8] : b[15:8], cc[0] ? a[7:0] : b[7:0]};
            {6'h12, 5'h0C}: d = {b[31:16], 16'h0000};
            {6'h12, 5'h0D}: d = {b[15:0], 16'h0000};
            {6'h12, 5'h04}: d = {1'b0, b[31:24], 7'h00, 1'b0, b[23:16], 7'h00};
            default: return r;
        endcase
        if (!p || (i[5:0] == 6'h12 && i[25:21] != 5'h00)) r.exc_ri = 1'b1;
        else if (!en) r.exc_dis = 1'b1;
        else begin
            r.wr_en = 1'b1;
            r.dest = i[15:11];
            r.data = d;
        end
        return r;
    endfunction

    task automatic issue_one(input logic v, input logic [31:0] i, input logic [3:0] cc,
                             input logic p, input logic en);
        logic [31:0] a;
        logic [31:0] b;
        a = $urandom;
        b = $urandom;
        pipe.step(v, i, a, b, cc, p, en);
        expq.push_back(model(v, i, a, b, cc, p, en));
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Compares each cycle's result with the oldest note
    initial begin
        int n;
        dsp_pse_pkg::result_s e;
        forever begin
            @(posedge core_clk);
            n = expq.size();
            @(negedge core_clk);
            if (n > 0) begin
                e = expq.pop_front();
                `CHK("wr_en", e.wr_en, result.wr_en)
                `CHK("exc_ri", e.exc_ri, result.exc_ri)
                `CHK("exc_dis", e.exc_dis, result.exc_dis)
                `CHK("dest", e.dest, result.dest)
                `CHK("data", e.data, result.data)
            end
        end
    end

    initial begin
        #20000;
        n_fail++;
        wrap_up();
    end

    initial begin
        logic [10:0] fs;
        logic [31:0] i;
        int r;
        void'($urandom(59));
        repeat (20) @(posedge core_clk);
        #1 rst_n = 1'b1;
        // Mixed back-to-back traffic with corrupted decodes and exceptions
        for (int k = 0; k < 300; k++) begin
            fs = ops[$urandom % 6];
            r = (k < 60) ? 7 : $urandom % 8;
            i = enc((fs[10:5] == 6'h12 && r != 3) ? 5'h00 : 5'($urandom), fs);
            if (r == 0) i[31:26] = i[31:26] ^ (6'($urandom) | 6'h01);
            if (r == 1) i[10:6] = 5'($urandom);
            if (r == 2) i[5:0] = i[5:0] ^ (6'($urandom) | 6'h01);
            issue_one(r < 4 || ($urandom % 6) != 0, i, 4'($urandom),
                      r < 4 || ($urandom % 5) != 0, r < 4 || ($urandom % 5) != 0);
        end
        // Every flag pattern for byte selection
        for (int c = 0; c < 16; c++) begin
            issue_one(1'b1, enc(5'($urandom), 11'h223), 4'(c), 1'b1, 1'b1);
        end
        issue_one(1'b0, 32'h00000000, 4'h0, 1'b1, 1'b1);
        repeat (2) @(posedge core_clk);
        // Reset in mid-run clears the result at once
        #1 rst_n = 1'b0;
        #1;
        `CHK("result_o in reset", dsp_pse_pkg::result_s'('0), result)
        @(posedge core_clk);
        #1 rst_n = 1'b1;
        issue_one(1'b1, enc(5'h00, 11'h244), 4'h0, 1'b1, 1'b1);
        repeat (3) @(posedge core_clk);
        wrap_up();
    end
endmodule

`default_nettype wire
